// ==== src/backup_supervisor_regs.svh ====
`ifndef BACKUP_SUPERVISOR_REGS_SVH
`define BACKUP_SUPERVISOR_REGS_SVH

`define CELL_TEST_TRIGGER_ADDR 8'h0d
`define STATUS_ADDR 8'h00
`define TEST_CONFIG_ADDR 8'h0c
`define STATUS_VALID_BIT 0
`define STATUS_LOW_CELL_BIT 1
`define TEST_CONFIG_RESET 8'h00
`define TICK_HZ 16
`define LOAD_TIME_MS 1000
`define LOAD_TICKS ((`LOAD_TIME_MS * `TICK_HZ) / 1000)
`define INTERVAL_TIME_HR 24
`define INTERVAL_TICKS (`INTERVAL_TIME_HR * 3600 * `TICK_HZ)
`define BLINK_HALF_MS 500
`define BLINK_TICKS ((`BLINK_HALF_MS * `TICK_HZ) / 1000)
`define CLK_MHZ 40
`define HOLD_TIME_NS 15000
`define HOLD_CYCLES ((`HOLD_TIME_NS * `CLK_MHZ) / 1000)
`define TIMEOUT_TIME_US 140000
`define TIMEOUT_CYCLES ((`TIMEOUT_TIME_US * `CLK_MHZ) / 1)

`endif

// ==== src/backup_supervisor_pkg.sv ====
package backup_supervisor_pkg;
  typedef enum logic [1:0] {
    GATE_OPEN = 2'b00,
    GATE_DRAIN = 2'b01,
    GATE_SHUT = 2'b10
  } gate_state_t;
  typedef enum logic [1:0] {
    TEST_IDLE = 2'b00,
    TEST_LOAD = 2'b01,
    TEST_JUDGE = 2'b10
  } test_state_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage : backup_supervisor_pkg

// ==== src/sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sync2
`default_nettype wire

// ==== src/tick_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module tick_counter #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] count;
  always_ff @(posedge clk) begin
    if (srst || clear) begin
      count <= '0;
      done <= 1'b0;
    end else if (step && !done) begin
      if (count + W'(1) >= limit) begin
        done <= 1'b1;
      end
      count <= count + W'(1);
    end
  end
endmodule : tick_counter
`default_nettype wire

// ==== src/backup_supervisor.sv ====
// Function
// - Chip-select pass path stays off, input floating, while reset is asserted, once any write hold window has ended.
// - Reset with select input high disables the pass path immediately.
// - Reset with select low disables at select rise or hold window end.
// - After any reset, pass path stays off for the full timeout.
// - Active pull-up on chip-select output while path is off, released otherwise.
// - Data-valid flag is cleared at power-on reset.
// - Every status register read sets the data-valid flag, except while internal supply collapse is present.
// - Internal supply collapse clears data-valid, overriding a recent read.
// - Default test source select low uses internal load and threshold only.
// - One battery test runs whenever main supply rises above threshold.
// - Every issued reset, manual or watchdog, runs a battery test.
// - After power-on test, repeat test every 24 hours with supply.
// - Load cell one second; trip sets low output and status bit.
// - Selected low-cell output blinks at 1Hz, half second each phase.
// - Periodic tests stop while low-cell indication is active.
// - Any trigger register write tests; pass clears flag, resumes periodic.
// - Freshness seal blocks backup until supply rises then falls below.
// - Test configuration register is read-only; writes have no effect.
`timescale 1ns/1ps
`default_nettype none
`include "backup_supervisor_regs.svh"
module backup_supervisor #(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
  parameter int INTERVAL_TICKS = `INTERVAL_TICKS,
  parameter int HOLD_CYCLES = `HOLD_CYCLES,
  parameter int LOAD_TICKS = `LOAD_TICKS,
  parameter int BLINK_TICKS = `BLINK_TICKS
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SLOW_TICK,
  input wire logic SUPPLY_OK,
  input wire logic SUPPLY_ABOVE_CELL,
  input wire logic CORE_COLLAPSE,
  input wire logic SUPERVISOR_RESET,
  input wire logic ISSUED_RESET,
  input wire logic CELL_BELOW_TRIP,
  input wire logic SELECT_IN,
  input wire logic BLINK_ENABLE,
  input wire logic TEST_SOURCE_SELECT,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic PASS_ENABLE,
  output logic SELECT_IN_FLOAT,
  output logic SELECT_PULLUP_EN,
  output logic CELL_LOAD_EN,
  output logic INTERNAL_LOAD_SEL,
  output logic LOW_CELL_OUTPUT_N,
  output logic BACKUP_ENABLE
);
  backup_supervisor_pkg::reg_req_t req;
  backup_supervisor_pkg::gate_state_t gate;
  backup_supervisor_pkg::test_state_t test;
  logic [6:0] raw_in;
  logic [6:0] s_in;
  logic tick;
  logic supply_ok;
  logic above_cell;
  logic collapse;
  logic rst_in;
  logic issued;
  logic below_trip;
  logic select_s;
  logic rst_q;
  logic supply_q;
  logic issued_q;
  logic tick_q;
  logic step;
  logic [31:0] hold_count;
  logic [31:0] timeout_count;
  logic data_valid;
  logic low_cell_flag;
  logic tripped;
  logic periodic_due;
  logic start_test;
  logic load_done;
  logic interval_done;
  logic blink_done;
  logic blink_phase;
  logic seal;
  logic seen_supply;
  logic [7:0] next_rdata;

  // Address decode shared by the flag update and the read mux
  function automatic logic is_status(input logic [7:0] a);
    return a == `STATUS_ADDR;
  endfunction : is_status

  function automatic logic is_trigger(input logic [7:0] a);
    return a == `CELL_TEST_TRIGGER_ADDR;
  endfunction : is_trigger

  function automatic logic [31:0] inc32(input logic [31:0] v);
    return v + 32'd1;
  endfunction : inc32

  // Rising edge of a level against its one-cycle delayed copy
  function automatic logic rise(input logic now, input logic was);
    return now && !was;
  endfunction : rise

  assign req = '{rd: REG_RD, wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};
  assign raw_in = {SELECT_IN, CELL_BELOW_TRIP, ISSUED_RESET,
                   SUPERVISOR_RESET, CORE_COLLAPSE, SUPPLY_ABOVE_CELL,
                   SUPPLY_OK};

  sync2 #(.W(7)) u_sync (
    .clk(CLK),
    .srst(SRST),
    .d(raw_in),
    .q(s_in)
  );
  // Timebase is async to CLK, so it crosses like the pins
  sync2 #(.W(1)) u_tick_sync (
    .clk(CLK),
    .srst(SRST),
    .d(SLOW_TICK),
    .q(tick)
  );
  assign supply_ok = s_in[0];
  assign above_cell = s_in[1];
  assign collapse = s_in[2];
  assign rst_in = s_in[3];
  assign issued = s_in[4];
  assign below_trip = s_in[5];
  assign select_s = s_in[6];

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rst_q <= 1'b0;
      supply_q <= 1'b0;
      issued_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      rst_q <= rst_in;
      supply_q <= supply_ok;
      issued_q <= issued;
      tick_q <= tick;
    end
  end
  assign step = rise(tick, tick_q);

  // Chip-select gate; hold counts a write cycle to completion
  always_ff @(posedge CLK) begin
    if (SRST) begin
      gate <= backup_supervisor_pkg::GATE_SHUT;
      hold_count <= '0;
      timeout_count <= '0;
    end else begin
      unique case (gate)
        backup_supervisor_pkg::GATE_OPEN: begin
          if (rise(rst_in, rst_q)) begin
            hold_count <= '0;
            timeout_count <= '0;
            if (select_s) begin
              gate <= backup_supervisor_pkg::GATE_SHUT;
            end else begin
              gate <= backup_supervisor_pkg::GATE_DRAIN;
            end
          end
        end
        backup_supervisor_pkg::GATE_DRAIN: begin
          hold_count <= inc32(hold_count);
          if (select_s || inc32(hold_count) >= 32'(HOLD_CYCLES)) begin
            gate <= backup_supervisor_pkg::GATE_SHUT;
          end
        end
        backup_supervisor_pkg::GATE_SHUT: begin
          // Timeout restarts while reset is held
          if (rst_in) begin
            timeout_count <= '0;
          end else if (inc32(timeout_count) >= 32'(TIMEOUT_CYCLES)) begin
            gate <= backup_supervisor_pkg::GATE_OPEN;
          end else begin
            timeout_count <= inc32(timeout_count);
          end
        end
        default: gate <= backup_supervisor_pkg::GATE_SHUT;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      PASS_ENABLE <= 1'b0;
      SELECT_IN_FLOAT <= 1'b1;
      SELECT_PULLUP_EN <= 1'b1;
    end else begin
      PASS_ENABLE <= gate != backup_supervisor_pkg::GATE_SHUT;
      SELECT_IN_FLOAT <= gate == backup_supervisor_pkg::GATE_SHUT;
      SELECT_PULLUP_EN <= gate == backup_supervisor_pkg::GATE_SHUT;
    end
  end

  // Collapse wins over a read in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      data_valid <= 1'b0;
    end else if (collapse) begin
      data_valid <= 1'b0;
    end else if (req.rd && is_status(req.addr)) begin
      data_valid <= 1'b1;
    end
  end

  assign periodic_due = interval_done && !low_cell_flag;
  assign start_test = rise(supply_ok, supply_q)
                   || rise(issued, issued_q)
                   || (req.wr && is_trigger(req.addr))
                   || periodic_due;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      test <= backup_supervisor_pkg::TEST_IDLE;
      tripped <= 1'b0;
    end else begin
      unique case (test)
        backup_supervisor_pkg::TEST_IDLE: begin
          tripped <= 1'b0;
          if (start_test && supply_ok) begin
            test <= backup_supervisor_pkg::TEST_LOAD;
          end
        end
        backup_supervisor_pkg::TEST_LOAD: begin
          // Any dip inside the load window latches a failure
          if (below_trip) begin
            tripped <= 1'b1;
          end
          if (load_done) begin
            test <= backup_supervisor_pkg::TEST_JUDGE;
          end
        end
        backup_supervisor_pkg::TEST_JUDGE: begin
          test <= backup_supervisor_pkg::TEST_IDLE;
        end
        default: test <= backup_supervisor_pkg::TEST_IDLE;
      endcase
    end
  end

  tick_counter #(.W(32)) u_load (
    .clk(CLK),
    .srst(SRST),
    .clear(test != backup_supervisor_pkg::TEST_LOAD),
    .step(step),
    .limit(32'(LOAD_TICKS)),
    .done(load_done)
  );
  // Periodic count restarts after every test
  tick_counter #(.W(32)) u_interval (
    .clk(CLK),
    .srst(SRST),
    .clear(!supply_ok || test != backup_supervisor_pkg::TEST_IDLE
           || low_cell_flag),
    .step(step),
    .limit(32'(INTERVAL_TICKS)),
    .done(interval_done)
  );
  tick_counter #(.W(32)) u_blink (
    .clk(CLK),
    .srst(SRST),
    .clear(blink_done),
    .step(step),
    .limit(32'(BLINK_TICKS)),
    .done(blink_done)
  );

  always_ff @(posedge CLK) begin
    if (SRST) begin
      low_cell_flag <= 1'b0;
    end else if (test == backup_supervisor_pkg::TEST_JUDGE) begin
      low_cell_flag <= tripped;
    end
  end

  // Phase parks low so a fresh flag shows solid first
  always_ff @(posedge CLK) begin
    if (SRST) begin
      blink_phase <= 1'b0;
    end else if (!low_cell_flag) begin
      blink_phase <= 1'b0;
    end else if (blink_done) begin
      blink_phase <= !blink_phase;
    end
  end

  // Seal cleared only by a full rise and fall of main supply
  always_ff @(posedge CLK) begin
    if (SRST) begin
      seal <= 1'b1;
      seen_supply <= 1'b0;
    end else if (seal) begin
      if (supply_ok) begin
        seen_supply <= 1'b1;
      end else if (seen_supply && !above_cell) begin
        seal <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (is_status(req.addr)) begin
      next_rdata[`STATUS_VALID_BIT] = data_valid;
      next_rdata[`STATUS_LOW_CELL_BIT] = low_cell_flag;
    end else if (req.addr == `TEST_CONFIG_ADDR) begin
      next_rdata = `TEST_CONFIG_RESET;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
      CELL_LOAD_EN <= 1'b0;
      INTERNAL_LOAD_SEL <= 1'b1;
      LOW_CELL_OUTPUT_N <= 1'b1;
      BACKUP_ENABLE <= 1'b0;
    end else begin
      if (req.rd) begin
        REG_RDATA <= next_rdata;
      end
      CELL_LOAD_EN <= test == backup_supervisor_pkg::TEST_LOAD;
      INTERNAL_LOAD_SEL <= !TEST_SOURCE_SELECT;
      LOW_CELL_OUTPUT_N <= !(low_cell_flag
                             && !(BLINK_ENABLE && blink_phase));
      BACKUP_ENABLE <= !seal && !supply_ok;
    end
  end
endmodule : backup_supervisor
`default_nettype wire

// ==== dv/backup_supervisor_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module backup_supervisor_monitor #(
  parameter int TIMEOUT_CYCLES = 50,
  parameter int HOLD_CYCLES = 40
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CORE_COLLAPSE,
  input wire logic SUPERVISOR_RESET,
  input wire logic SELECT_IN,
  input wire logic TEST_SOURCE_SELECT,
  input wire logic SUPPLY_OK,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic PASS_ENABLE,
  input wire logic SELECT_IN_FLOAT,
  input wire logic SELECT_PULLUP_EN,
  input wire logic CELL_LOAD_EN,
  input wire logic INTERNAL_LOAD_SEL,
  input wire logic LOW_CELL_OUTPUT_N
);
  logic [31:0] hi_cnt;
  logic [31:0] lo_cnt;
  logic [3:0] col;
  logic seen;
  logic any_rd;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  always_ff @(posedge CLK) begin
    if (SRST || !SUPERVISOR_RESET) hi_cnt <= 32'h0;
    else hi_cnt <= hi_cnt + 32'h1;
  end
  always_ff @(posedge CLK) begin
    if (SRST || SUPERVISOR_RESET) lo_cnt <= 32'h0;
    else lo_cnt <= lo_cnt + 32'h1;
  end
  always_ff @(posedge CLK) begin
    col <= {col[2:0], CORE_COLLAPSE};
  end
  // Only reads clear of the collapse sync lag count as setting the flag
  always_ff @(posedge CLK) begin
    if (SRST || CORE_COLLAPSE) seen <= 1'b0;
    else if (REG_RD && REG_ADDR == 8'h00 && col == 4'h0) seen <= 1'b1;
  end
  always_ff @(posedge CLK) begin
    if (SRST) any_rd <= 1'b0;
    else if (REG_RD && REG_ADDR == 8'h00) any_rd <= 1'b1;
  end
  property p_float;
    hi_cnt > HOLD_CYCLES + 4 |-> SELECT_IN_FLOAT && !PASS_ENABLE;
  endproperty
  a_float: assert property (p_float) else $error("float mismatch");
  property p_pullup;
    SELECT_PULLUP_EN == !PASS_ENABLE;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup mismatch");
  property p_high;
    (SUPERVISOR_RESET && SELECT_IN) [*5] |-> !PASS_ENABLE;
  endproperty
  a_high: assert property (p_high) else $error("gate open, select high");
  property p_hold;
    hi_cnt > HOLD_CYCLES + 4 |-> !PASS_ENABLE;
  endproperty
  a_hold: assert property (p_hold) else $error("gate open past hold");
  property p_timeout;
    $rose(PASS_ENABLE) |-> lo_cnt > TIMEOUT_CYCLES / 2;
  endproperty
  a_timeout: assert property (p_timeout) else $error("gate opened early");
  property p_fresh;
    REG_RD && REG_ADDR == 8'h00 && !any_rd |=> !REG_RDATA[0];
  endproperty
  a_fresh: assert property (p_fresh) else $error("valid set at start");
  property p_set;
    REG_RD && REG_ADDR == 8'h00 && seen && col == 4'h0 |=> REG_RDATA[0];
  endproperty
  a_set: assert property (p_set) else $error("valid not set by read");
  property p_clear;
    CORE_COLLAPSE [*4] ##0 (REG_RD && REG_ADDR == 8'h00) |=> !REG_RDATA[0];
  endproperty
  a_clear: assert property (p_clear) else $error("valid kept");
  property p_int;
    !TEST_SOURCE_SELECT [*3] |-> INTERNAL_LOAD_SEL;
  endproperty
  a_int: assert property (p_int) else $error("external load used");
  property p_load;
    $rose(CELL_LOAD_EN) |=> CELL_LOAD_EN [*8];
  endproperty
  a_load: assert property (p_load) else $error("load window short");
  property p_trig;
    (SUPPLY_OK && !CELL_LOAD_EN) [*6] ##0 (REG_WR && REG_ADDR == 8'h0d)
      |-> ##[1:4] CELL_LOAD_EN;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger ignored");
  c_trip: cover property ($fell(LOW_CELL_OUTPUT_N));
  c_open: cover property ($rose(PASS_ENABLE));
  c_hold: cover property (SUPERVISOR_RESET && !SELECT_IN && $fell(PASS_ENABLE));
endmodule : backup_supervisor_monitor
bind backup_supervisor backup_supervisor_monitor #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) mon (
  .CLK(CLK), .SRST(SRST), .CORE_COLLAPSE(CORE_COLLAPSE),
  .SUPERVISOR_RESET(SUPERVISOR_RESET), .SELECT_IN(SELECT_IN),
  .TEST_SOURCE_SELECT(TEST_SOURCE_SELECT), .SUPPLY_OK(SUPPLY_OK),
  .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA), .PASS_ENABLE(PASS_ENABLE),
  .SELECT_IN_FLOAT(SELECT_IN_FLOAT), .SELECT_PULLUP_EN(SELECT_PULLUP_EN),
  .CELL_LOAD_EN(CELL_LOAD_EN), .INTERNAL_LOAD_SEL(INTERNAL_LOAD_SEL),
  .LOW_CELL_OUTPUT_N(LOW_CELL_OUTPUT_N));
`default_nettype wire

// ==== dv/cs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cs_host_model (
  input wire logic clk,
  input wire logic run,
  input wire logic slow,
  output logic select
);
  logic [7:0] cnt;
  logic [7:0] len;
  // Slow cycles outlast the hold window, fast ones fit inside it
  assign len = slow ? 8'h64 : 8'h04;
  always_ff @(posedge clk) begin
    if (!run) cnt <= 8'h0;
    else if (cnt >= len + 8'h3) cnt <= 8'h0;
    else cnt <= cnt + 8'h1;
  end
  assign select = !run || cnt >= len;
endmodule : cs_host_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TO = 50;
  localparam int HOLD = 40;
  localparam int LOAD = 4;
  logic clk, srst, tick, sup, above, coll, sres, ires, trip, sel, blink;
  logic tsrc, rd, wr, run, slow, pass, flt, pull, load, isel, low_n, bak;
  logic pl, pn;
  logic [7:0] addr, wdata, rdata, r8;
  int n_mismatch, n_compared, seed, i, k, e, t;
  backup_supervisor #(.TIMEOUT_CYCLES(TO), .INTERVAL_TICKS(20),
    .HOLD_CYCLES(HOLD), .LOAD_TICKS(LOAD), .BLINK_TICKS(2)) DUT (
    .CLK(clk), .SRST(srst), .SLOW_TICK(tick), .SUPPLY_OK(sup),
    .SUPPLY_ABOVE_CELL(above), .CORE_COLLAPSE(coll),
    .SUPERVISOR_RESET(sres), .ISSUED_RESET(ires), .CELL_BELOW_TRIP(trip),
    .SELECT_IN(sel), .BLINK_ENABLE(blink), .TEST_SOURCE_SELECT(tsrc),
    .REG_RD(rd), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .PASS_ENABLE(pass), .SELECT_IN_FLOAT(flt),
    .SELECT_PULLUP_EN(pull), .CELL_LOAD_EN(load), .INTERNAL_LOAD_SEL(isel),
    .LOW_CELL_OUTPUT_N(low_n), .BACKUP_ENABLE(bak));
  cs_host_model HOST (.clk(clk), .run(run), .slow(slow), .select(sel));
  function automatic logic [7:0] st(input logic v, input logic lo);
    return {6'h0, lo, v};
  endfunction : st
  task summarize;
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task rw(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= r;
    wr <= !r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
  endtask : rw
  // Bounded wait on the load enable; a hang ends the run
  task wl(input logic v);
    for (k = 0; k < 400 && load !== v; k++) @(posedge clk);
    if (load !== v) begin
      n_mismatch++;
      $display("wrong value at %0t: load enable stuck", $time);
      summarize();
    end
  endtask : wl
  task watch(input int n);
    e = 0;
    t = 0;
    repeat (n) begin
      @(negedge clk);
      if (load && !pl) t++;
      if (low_n && !pn) e++;
      pl = load;
      pn = low_n;
    end
  endtask : watch
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    forever begin
      cyc(4);
      tick <= ~tick;
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    seed = 32'h4c30518d;
    {srst, sup, above, pl, pn} = 5'h1f;
    {tick, coll, sres, ires, trip, blink, tsrc, rd, wr, run, slow} = 11'h0;
    {addr, wdata} = 16'h0;
    n_mismatch = 0;
    n_compared = 0;
    cyc(2);
    srst <= 1'b0;
    rw(1'b1, 8'h00, 8'h00);
    chk(rdata, st(1'b0, 1'b0));
    wl(1'b0);
    rw(1'b1, 8'h00, 8'h00);
    chk(rdata, st(1'b1, 1'b0));
    for (i = 0; i < 6; i++) begin
      r8 = $random(seed);
      rw(1'b0, (i < 2) ? 8'h0c : (r8 | 8'h10), r8);
      rw(1'b1, (i < 2) ? 8'h0c : (r8 | 8'h10), 8'h00);
      chk(rdata, 8'h00);
    end
    @(posedge clk);
    coll <= 1'b1;
    cyc(5);
    rw(1'b1, 8'h00, 8'h00);
    chk(rdata, st(1'b0, 1'b0));
    @(posedge clk);
    coll <= 1'b0;
    cyc(5);
    rw(1'b1, 8'h00, 8'h00);
    rw(1'b1, 8'h00, 8'h00);
    chk(rdata, st(1'b1, 1'b0));
    @(posedge clk);
    trip <= 1'b1;
    tsrc <= 1'b1;
    cyc(5);
    chk(isel, 8'h00);
    tsrc <= 1'b0;
    rw(1'b0, 8'h0d, r8);
    wl(1'b1);
    for (i = 0; i < 100 && load; i++) @(posedge clk);
    chk(8'(i > LOAD * 8 - 9 && i < LOAD * 8 + 9), 8'h01);
    trip <= 1'b0;
    blink <= 1'b1;
    cyc(4);
    chk(isel, 8'h01);
    rw(1'b1, 8'h00, 8'h00);
    chk(rdata, st(1'b1, 1'b1));
    watch(400);
    chk(8'(e > 10 && e < 15), 8'h01);
    chk(8'(t), 8'h00);
    @(posedge clk);
    blink <= 1'b0;
    rw(1'b0, 8'h0d, $random(seed));
    wl(1'b1);
    wl(1'b0);
    cyc(4);
    chk(low_n, 8'h01);
    rw(1'b1, 8'h00, 8'h00);
    chk(rdata, st(1'b1, 1'b0));
    watch(400);
    chk(8'(t > 1), 8'h01);
    wl(1'b0);
    @(posedge clk);
    ires <= 1'b1;
    wl(1'b1);
    chk(load, 8'h01);
    ires <= 1'b0;
    sres <= 1'b1;
    cyc(5);
    chk(pass, 8'h00);
    sres <= 1'b0;
    for (i = 0; i < TO + 20 && !pass; i++) @(posedge clk);
    chk(8'(i > TO / 2 && pass), 8'h01);
    run <= 1'b1;
    slow <= 1'b1;
    cyc(2);
    sres <= 1'b1;
    cyc(HOLD + 6);
    chk({sel, pass}, 8'h00);
    cyc(200);
    chk({pass, flt, pull}, 8'h03);
    sres <= 1'b0;
    cyc(TO / 2);
    chk(pass, 8'h00);
    for (i = 0; i < TO + 20 && !pass; i++) @(posedge clk);
    #1;
    chk({pass, flt, pull}, 8'h04);
    @(posedge clk);
    slow <= 1'b0;
    cyc(10);
    for (i = 0; i < 20 && sel; i++) @(posedge clk);
    sres <= 1'b1;
    cyc(12);
    chk(pass, 8'h00);
    sres <= 1'b0;
    @(posedge clk);
    run <= 1'b0;
    srst <= 1'b1;
    {sup, above} <= 2'h0;
    cyc(2);
    srst <= 1'b0;
    cyc(10);
    chk(bak, 8'h00);
    {sup, above} <= 2'h3;
    wl(1'b1);
    chk(load, 8'h01);
    wl(1'b0);
    {sup, above} <= 2'h0;
    cyc(6);
    chk(bak, 8'h01);
    summarize();
  end
endmodule : tb
`default_nettype wire
